// *** hw/tisp_defs.vh ***
`ifndef TISP_DEFS_VH
`define TISP_DEFS_VH
`define TISP_EVT_W 24
`define TISP_TIME_W 32
`define TISP_INT_W 8
`define TISP_STAMP_W 48
`define TISP_COARSE_PS 20
`define TISP_INTERP_PS 1
`define TISP_COARSE_NS 2
`define TISP_INTERP_TENTH_NS 1
`define TISP_MISS_BIAS 1
`define TISP_SMP_START 1'b0
`define TISP_SMP_STOP 1'b1
`endif

// *** hw/tisp_rollover.v ***
`timescale 1ns/1ps
module tisp_rollover #(
  parameter W  = 24,
  parameter OW = 40
) (
  input  wire          i_clk_sys,
  input  wire          i_reset,
  input  wire          i_clear,
  input  wire          i_valid,
  input  wire [W-1:0]  i_raw,
  input  wire [OW-1:0] i_corr,
  output wire [OW-1:0] o_value
);
  reg  [W-1:0]  prev;
  reg           have_prev;
  reg  [OW-1:0] accum;
  wire          wrap = have_prev && (i_raw < prev);
  wire [OW-1:0] next_accum = wrap ? accum + i_corr : accum;
  assign o_value = {{(OW-W){1'b0}}, i_raw} + next_accum;
  always @(posedge i_clk_sys) begin
    if (i_reset || i_clear) begin
      prev      <= {W{1'b0}};
      have_prev <= 1'b0;
      accum     <= {OW{1'b0}};
    end else if (i_valid) begin
      prev      <= i_raw;
      have_prev <= 1'b1;
      accum     <= next_accum;
    end
  end
endmodule

// *** hw/tisp_stamp.v ***
`timescale 1ns/1ps
`include "tisp_defs.vh"
module tisp_stamp #(
  parameter TW = 40,
  parameter IW = 8,
  parameter SW = 48
) (
  input  wire [TW-1:0] i_time,
  input  wire [IW-1:0] i_interp,
  output wire [SW-1:0] o_stamp
);
  // stamp in tenths of a ns: time*20 - int*1
  wire [SW-1:0] t_ext = {{(SW-TW){1'b0}}, i_time};
  wire [SW-1:0] i_ext = {{(SW-IW){1'b0}}, i_interp};
  assign o_stamp = (t_ext << 4) + (t_ext << 2) - i_ext;
endmodule

// *** hw/tisp_top.v ***
`timescale 1ns/1ps
`include "tisp_defs.vh"
// Behaviour
// - start events on odd samples, monotonic
// - start event wrap adds event correction onward
// - stop event wrap corrected the same way
// - time wrap adds time correction onward
// - stamp is time*2ns minus int*0.1ns
// - offset added to stop stamps only
// - interval is stop stamp minus start
// - missed start is start delta minus one
// - missed stop is stop delta minus one
// - reversed order gives negative interval
// - channel assignment is a configuration input
// - out-of-range reversal corrected as rollover
module tisp_top #(
  parameter EW = `TISP_EVT_W,
  parameter TW = `TISP_TIME_W,
  parameter IW = `TISP_INT_W,
  parameter SW = `TISP_STAMP_W,
  parameter XW = 40
) (
  input  wire                 i_clk_sys,
  input  wire                 i_reset,
  input  wire                 i_clear,
  input  wire                 i_s_valid,
  input  wire [EW-1:0]        i_s_event,
  input  wire [TW-1:0]        i_s_time,
  input  wire [IW-1:0]        i_s_interp,
  input  wire                 i_s_first_of_block,
  input  wire                 i_s_suppressed,
  input  wire [XW-1:0]        i_evt_corr,
  input  wire [XW-1:0]        i_time_corr,
  input  wire signed [SW-1:0] i_path_offset,
  input  wire [XW-1:0]        i_max_span,
  input  wire                 i_signed_mode,
  input  wire                 i_start_chan,
  output reg                  o_r_valid,
  output reg  signed [SW-1:0] o_r_interval,
  output reg  [XW-1:0]        o_r_missed_start,
  output reg  [XW-1:0]        o_r_missed_stop,
  output reg                  o_r_start_chan,
  output reg                  o_r_flags_start,
  output reg                  o_r_flags_stop
);
  reg           phase;
  reg  [XW-1:0] t_start;
  reg  [IW-1:0] i_start;
  reg  [XW-1:0] e_start;
  reg  [XW-1:0] e_start_prev;
  reg  [XW-1:0] e_stop_prev;
  reg           flags_start;
  reg  [XW-1:0] t_prev;
  reg           have_t;
  reg  [XW-1:0] t_accum;
  reg           pend_valid;
  reg  signed [SW-1:0] pend_int;
  reg           pend_fs;
  reg           pend_fp;
  wire [XW-1:0] e_start_cor;
  wire [XW-1:0] e_stop_cor;
  wire          is_start = (phase == `TISP_SMP_START);
  wire          is_stop  = (phase == `TISP_SMP_STOP);
  tisp_rollover #(.W(EW), .OW(XW)) u_ev_start (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_clear   (i_clear),
    .i_valid   (i_s_valid && is_start),
    .i_raw     (i_s_event),
    .i_corr    (i_evt_corr),
    .o_value   (e_start_cor)
  );
  tisp_rollover #(.W(EW), .OW(XW)) u_ev_stop (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_clear   (i_clear),
    .i_valid   (i_s_valid && is_stop),
    .i_raw     (i_s_event),
    .i_corr    (i_evt_corr),
    .o_value   (e_stop_cor)
  );
  // time rollover, with start/stop reversal tolerated in signed mode
  wire [XW-1:0] t_raw = {{(XW-TW){1'b0}}, i_s_time};
  wire          t_drop = have_t && (t_raw < t_prev);
  wire [XW-1:0] t_cur_lin = t_raw + t_accum;
  wire [XW-1:0] rev_span = t_start - t_cur_lin;
  // in signed mode a stop below the start is a reversal unless beyond the max span
  wire          stop_wrap = i_signed_mode ? (t_cur_lin < t_start && rev_span > i_max_span) : t_drop;
  wire          t_wrap = is_stop ? stop_wrap : (t_drop && !(i_signed_mode && t_raw + t_accum + i_time_corr - t_start <= i_max_span && t_raw + t_accum >= t_start));
  wire [XW-1:0] next_t_accum = t_wrap ? t_accum + i_time_corr : t_accum;
  // stop far above its start was taken before the wrap that the start got
  wire [XW-1:0] fwd_span = t_cur_lin - t_start;
  wire          stop_back = is_stop && i_signed_mode && t_cur_lin > t_start && fwd_span > i_max_span
                            && t_accum >= i_time_corr;
  wire [XW-1:0] t_cor = stop_back ? t_cur_lin - i_time_corr : t_raw + next_t_accum;
  wire [SW-1:0] stamp_start;
  wire [SW-1:0] stamp_now;
  tisp_stamp #(.TW(XW), .IW(IW), .SW(SW)) u_st_start (
    .i_time   (t_start),
    .i_interp (i_start),
    .o_stamp  (stamp_start)
  );
  tisp_stamp #(.TW(XW), .IW(IW), .SW(SW)) u_st_now (
    .i_time   (t_cor),
    .i_interp (i_s_interp),
    .o_stamp  (stamp_now)
  );
  wire signed [SW-1:0] stop_stamp = $signed(stamp_now) + i_path_offset;
  wire signed [SW-1:0] next_int = stop_stamp - $signed(stamp_start);
  always @(posedge i_clk_sys) begin
    if (i_reset || i_clear) begin
      phase        <= `TISP_SMP_START;
      t_start      <= {XW{1'b0}};
      i_start      <= {IW{1'b0}};
      e_start      <= {XW{1'b0}};
      e_start_prev <= {XW{1'b0}};
      e_stop_prev  <= {XW{1'b0}};
      flags_start  <= 1'b0;
      t_prev       <= {XW{1'b0}};
      have_t       <= 1'b0;
      t_accum      <= {XW{1'b0}};
      pend_valid   <= 1'b0;
      pend_int     <= {SW{1'b0}};
      pend_fs      <= 1'b0;
      pend_fp      <= 1'b0;
      o_r_valid        <= 1'b0;
      o_r_interval     <= {SW{1'b0}};
      o_r_missed_start <= {XW{1'b0}};
      o_r_missed_stop  <= {XW{1'b0}};
      o_r_start_chan   <= 1'b0;
      o_r_flags_start  <= 1'b0;
      o_r_flags_stop   <= 1'b0;
    end else begin
      o_r_valid <= 1'b0;
      if (i_s_valid) begin
        phase   <= ~phase;
        // scan resumes from the later raw count, so the wrap is not taken twice
        t_prev  <= stop_back ? t_start - t_accum : t_raw;
        have_t  <= 1'b1;
        t_accum <= next_t_accum;
        if (is_start) begin
          t_start     <= t_cor;
          i_start     <= i_s_interp;
          e_start     <= e_start_cor;
          flags_start <= i_s_first_of_block | i_s_suppressed;
        end else begin
          // result waits for next measurement's event counts for missed counts
          pend_valid   <= 1'b1;
          pend_int     <= next_int;
          pend_fs      <= flags_start;
          pend_fp      <= i_s_first_of_block | i_s_suppressed;
          e_start_prev <= e_start;
          e_stop_prev  <= e_stop_cor;
          if (pend_valid) begin
            o_r_valid        <= 1'b1;
            o_r_interval     <= pend_int;
            o_r_missed_start <= e_start - e_start_prev - `TISP_MISS_BIAS;
            o_r_missed_stop  <= e_stop_cor - e_stop_prev - `TISP_MISS_BIAS;
            o_r_start_chan   <= i_start_chan;
            o_r_flags_start  <= pend_fs;
            o_r_flags_stop   <= pend_fp;
          end
        end
      end
    end
  end
endmodule

// *** tb/tisp_monitor.sv ***
`timescale 1ns/1ps
module tisp_monitor #(parameter SW = 48, parameter XW = 40) (
  input logic                 i_clk_sys,
  input logic                 i_reset,
  input logic                 i_clear,
  input logic                 i_s_valid,
  input logic                 i_start_chan,
  input logic                 o_r_valid,
  input logic signed [SW-1:0] o_r_interval,
  input logic [XW-1:0]        o_r_missed_start,
  input logic [XW-1:0]        o_r_missed_stop,
  input logic                 o_r_start_chan,
  input logic                 o_r_flags_start,
  input logic                 o_r_flags_stop
);
  logic q;
  // a clear also moves the outputs, so no hold check on that edge
  always @(posedge i_clk_sys) q <= !i_clear && !i_reset;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_pulse_once: assert property (o_r_valid |=> !o_r_valid) else $error("long pulse");
  a_stop_cause: assert property (o_r_valid |-> $past(i_s_valid)) else $error("no stop");
  a_clear_quiet: assert property (i_clear |=> !o_r_valid [*3]) else $error("early");
  a_clear_zero: assert property ($past(i_clear) |->
    o_r_interval == 0 && o_r_missed_stop == 0) else $error("nz");
  a_chan_echo: assert property (o_r_valid |-> o_r_start_chan == $past(i_start_chan)) else $error("chan");
  a_span_hold: assert property (!o_r_valid && q |-> $stable(o_r_interval)) else $error("moved");
  a_miss_hold: assert property (!o_r_valid && q |->
    $stable({o_r_missed_start, o_r_missed_stop})) else $error("miss");
  a_flag_hold: assert property (!o_r_valid && q |->
    $stable({o_r_flags_start, o_r_flags_stop})) else $error("flag");
  c_neg: cover property (o_r_valid && o_r_interval[SW-1]);
  c_clr: cover property (i_clear);
  c_zero: cover property (o_r_valid && o_r_missed_start == 0);
endmodule
bind tisp_top tisp_monitor #(.SW(SW), .XW(XW)) u_mon (
  .i_clk_sys        (i_clk_sys),
  .i_reset          (i_reset),
  .i_clear          (i_clear),
  .i_s_valid        (i_s_valid),
  .i_start_chan     (i_start_chan),
  .o_r_valid        (o_r_valid),
  .o_r_interval     (o_r_interval),
  .o_r_missed_start (o_r_missed_start),
  .o_r_missed_stop  (o_r_missed_stop),
  .o_r_start_chan   (o_r_start_chan),
  .o_r_flags_start  (o_r_flags_start),
  .o_r_flags_stop   (o_r_flags_stop)
);

// *** tb/tisp_src.sv ***
`timescale 1ns/1ps
module tisp_src (
  input  logic        i_clk_sys,
  output logic        o_valid = 0,
  output logic [23:0] o_event = 0,
  output logic [31:0] o_time = 0,
  output logic [7:0]  o_interp = 0,
  output logic        o_fob = 0,
  output logic        o_sup = 0
);
  // lets a scenario send stop samples with both status bits low
  logic mute_stop = 0;
  task automatic smp(input logic [23:0] e, input logic [31:0] t, input logic [7:0] n, input logic s);
    @(negedge i_clk_sys);
    o_valid = 1;
    {o_event, o_time, o_interp, o_fob, o_sup} = {e, t, n, !s, s && !mute_stop};
  endtask
  // start always ahead of its stop, even when captured later
  task automatic pair(input logic [23:0] e1, input logic [31:0] t1, input logic [7:0] n1,
                      input logic [23:0] e2, input logic [31:0] t2, input logic [7:0] n2);
    smp(e1, t1, n1, 1'b0);
    smp(e2, t2, n2, 1'b1);
    @(negedge i_clk_sys);
    o_valid = 0;
    // idle lines show no stale sample
    {o_event, o_time, o_interp} = ~{o_event, o_time, o_interp};
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        i_clk_sys = 0, i_reset = 1, i_clear = 0, i_signed_mode = 0, i_start_chan = 0;
  logic        i_s_valid, i_s_first_of_block, i_s_suppressed, o_r_valid, o_r_start_chan;
  logic        o_r_flags_start, o_r_flags_stop;
  logic [23:0] i_s_event;
  logic [31:0] i_s_time;
  logic [7:0]  i_s_interp;
  logic [39:0] i_evt_corr = 40'h14, i_time_corr = 40'h3E8, i_max_span = 40'h32;
  logic [39:0] o_r_missed_start, o_r_missed_stop;
  logic [47:0] i_path_offset = 48'h25, o_r_interval;
  int          miscompares = 0, num_checks = 0;
  tisp_src src (.i_clk_sys, .o_valid(i_s_valid), .o_event(i_s_event), .o_time(i_s_time),
    .o_interp(i_s_interp), .o_fob(i_s_first_of_block), .o_sup(i_s_suppressed));
  tisp_top dut (
    .i_clk_sys          (i_clk_sys),
    .i_reset            (i_reset),
    .i_clear            (i_clear),
    .i_s_valid          (i_s_valid),
    .i_s_event          (i_s_event),
    .i_s_time           (i_s_time),
    .i_s_interp         (i_s_interp),
    .i_s_first_of_block (i_s_first_of_block),
    .i_s_suppressed     (i_s_suppressed),
    .i_evt_corr         (i_evt_corr),
    .i_time_corr        (i_time_corr),
    .i_path_offset      (i_path_offset),
    .i_max_span         (i_max_span),
    .i_signed_mode      (i_signed_mode),
    .i_start_chan       (i_start_chan),
    .o_r_valid          (o_r_valid),
    .o_r_interval       (o_r_interval),
    .o_r_missed_start   (o_r_missed_start),
    .o_r_missed_stop    (o_r_missed_stop),
    .o_r_start_chan     (o_r_start_chan),
    .o_r_flags_start    (o_r_flags_start),
    .o_r_flags_stop     (o_r_flags_stop)
  );
  initial forever #2 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [47:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic res(input logic [47:0] iv, ms, mp, input logic [2:0] fl);
    for (int k = 0; k < 3 && o_r_valid !== 1'b1; k++) @(negedge i_clk_sys);
    chk({o_r_valid, o_r_flags_start, o_r_flags_stop}, fl);
    chk(o_r_interval, iv);
    chk(o_r_missed_start, ms);
    chk(o_r_missed_stop, mp);
  endtask
  task automatic test_wrap;
    src.pair(24'hA, 32'h64, 8'h3, 24'h5, 32'h69, 8'h7);
    src.pair(24'hE, 32'hC8, 8'h0, 24'h9, 32'hE6, 8'h9);
    res(48'h85, 48'h3, 48'h3, 3'h7);
    chk(o_r_start_chan, 48'h0);
    src.pair(24'h2, 32'h12C, 8'h0, 24'h1, 32'h12D, 8'h0);
    res(48'h274, 48'h7, 48'hB, 3'h7);
    src.pair(24'h6, 32'h3E6, 8'h1, 24'h4, 32'h3, 8'h2);
    res(48'h39, 48'h3, 48'h2, 3'h7);
    src.pair(24'h7, 32'h9, 8'h0, 24'h6, 32'hC, 8'h0);
    res(48'h88, 48'h0, 48'h1, 3'h7);
    $display("wrap done");
  endtask
  task automatic test_signed;
    i_clear = 1;
    @(negedge i_clk_sys);
    {i_clear, i_signed_mode, i_start_chan} = 3'h3;
    src.mute_stop = 1'b1;
    src.pair(24'h1, 32'h1F4, 8'h0, 24'h1, 32'h1EA, 8'h0);
    src.pair(24'h2, 32'h3DE, 8'h0, 24'h2, 32'hA, 8'h0);
    res(-48'hA3, 48'h0, 48'h0, 3'h6);
    src.pair(24'h3, 32'h1E, 8'h0, 24'h3, 32'h28, 8'h0);
    res(48'h1B5, 48'h0, 48'h0, 3'h6);
    chk(o_r_start_chan, 48'h1);
    src.pair(24'h4, 32'h5, 8'h0, 24'h4, 32'h3E2, 8'h0);
    res(48'hED, 48'h0, 48'h0, 3'h6);
    src.pair(24'h5, 32'h14, 8'h0, 24'h5, 32'h1E, 8'h0);
    res(-48'hB7, 48'h0, 48'h0, 3'h6);
    $display("signed done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_reset = 0;
    test_wrap;
    test_signed;
    final_report;
  end
endmodule
